// ==== rtl/mrec_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module mrec_fifo #(
   parameter int W = mrec_pkg::DW,
   parameter int D = mrec_pkg::FIFO_D,
   parameter int AW = mrec_pkg::FIFO_AW
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // fill side and drain side
   mrec_strm_if.snk wr,
   mrec_strm_if.src rd
);
   import mrec_pkg::*;
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic [W-1:0] head_r;
   logic hv_r;
   logic push;
   logic pop;
   logic load;

   // head word sits in a register so the reader never sees raw memory
   assign wr.ready = (cnt_r != (AW+1)'(D));
   assign push = wr.valid && wr.ready;
   assign pop = hv_r && rd.ready;
   assign load = (!hv_r || pop) && (cnt_r != '0);
   assign rd.valid = hv_r;
   assign rd.data = head_r;

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wp_r] <= wr.data;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + AW'(1);
         end
         if (load) begin
            rp_r <= rp_r + AW'(1);
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         hv_r <= 1'b0;
         head_r <= '0;
      end else if (load) begin
         hv_r <= 1'b1;
         head_r <= mem[rp_r];
      end else if (pop) begin
         hv_r <= 1'b0;
      end
   end
endmodule : mrec_fifo
`default_nettype wire

// ==== rtl/mrec_pkg.sv ====
`default_nettype none
package mrec_pkg;
   localparam int DW = 16;
   localparam int CHW = 8;
   localparam int NW = 4;
   localparam int FIFO_D = 16;
   localparam int FIFO_AW = 4;
   localparam int SR_D = 4;
   localparam int SR_AW = 2;
   localparam int FIR_W = DW + 1;
   // divider phase that fires each slow enable (counter runs 0..3)
   localparam logic [1:0] PH_ZERO = 2'h0;
   localparam logic [1:0] PH_LAST4 = 2'h3;
   localparam logic [1:0] PH_STEP = 2'h1;
   localparam logic [DW-1:0] WORD_RST = 16'h0000;
   localparam logic [CHW-1:0] CH_ZERO = 8'h00;
   localparam logic [NW-1:0] NIB_RST = 4'h0;
   localparam logic [FIR_W-1:0] FIR_RST = 17'h0_0000;
   typedef enum logic [1:0] {PH_RUN, PH_DRAIN, PH_HOLD} mrec_phase_type;
endpackage : mrec_pkg
`default_nettype wire

// ==== rtl/mrec_strm_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface mrec_strm_if;
   import mrec_pkg::*;
   logic valid;
   logic ready;
   logic [DW-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : mrec_strm_if
`default_nettype wire

// ==== rtl/mrec_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module mrec_top (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // enable clear from surrounding logic
   input wire logic ce_clear,
   // sample stream in
   input wire logic [mrec_pkg::DW-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // filter reset and shift register tap
   input wire logic fir_rst,
   input wire logic [mrec_pkg::SR_AW-1:0] sr_addr,
   // generated enables
   output logic ce1,
   output logic ce2,
   output logic ce4,
   // rate changer outputs
   output logic [mrec_pkg::DW-1:0] sample_q,
   output logic [mrec_pkg::DW-1:0] ds_last_q,
   output logic [mrec_pkg::DW-1:0] ds_first_q,
   output logic [mrec_pkg::DW-1:0] us_copy_q,
   output logic [mrec_pkg::DW-1:0] us_zero_q,
   output logic [mrec_pkg::CHW-1:0] interleave_q,
   output logic [mrec_pkg::CHW-1:0] deint_ch0_q,
   output logic [mrec_pkg::CHW-1:0] deint_ch1_q,
   output logic [mrec_pkg::NW-1:0] ser_q,
   output logic [mrec_pkg::DW-1:0] deser_q,
   output logic [mrec_pkg::DW-1:0] sr_q,
   output logic [mrec_pkg::FIR_W-1:0] fir_q
);
   import mrec_pkg::*;

   function automatic logic at_phase(input logic [1:0] c, input logic [1:0] p);
      return c == p;
   endfunction : at_phase

   ////////////////////////////////////////////////////////////////////////////
   // input buffer: drained once per half-rate enable, so it really fills
   mrec_strm_if in_if ();
   mrec_strm_if out_if ();
   assign in_if.valid = in_valid;
   assign in_if.data = in_data;
   assign in_ready = in_if.ready;
   assign out_if.ready = ce2;

   mrec_fifo u_fifo (
      .clock(clock),
      .sys_rst(sys_rst),
      .wr(in_if),
      .rd(out_if)
   );

   ////////////////////////////////////////////////////////////////////////////
   // enable generation
   logic [1:0] div_r;
   logic clr_d_r;
   logic arm_r;
   logic release_p;
   logic sync;

   always_ff @(posedge clock) begin
      if (sys_rst || ce_clear) begin
         div_r <= PH_ZERO;
      end else begin
         div_r <= div_r + PH_STEP;
      end
   end

   // one clock, slow domains are enable pulses only; none while clearing
   assign ce1 = !sys_rst && !ce_clear;
   assign ce2 = ce1 && div_r[0];
   assign ce4 = ce1 && at_phase(div_r, PH_LAST4);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         clr_d_r <= 1'b0;
      end else begin
         clr_d_r <= ce_clear;
      end
   end
   assign release_p = clr_d_r && !ce_clear;

   // the first quarter-rate enable after release realigns the local blocks;
   // waiting for the slowest enable leaves room for the drain and hold phases
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         arm_r <= 1'b0;
      end else if (release_p) begin
         arm_r <= 1'b1;
      end else if (ce4) begin
         arm_r <= 1'b0;
      end
   end
   assign sync = ce4 && arm_r;

   ////////////////////////////////////////////////////////////////////////////
   // local frame counter of the blocks that do not follow the clear
   logic [1:0] lc_r;
   logic lc_last2;
   logic lc_last4;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         lc_r <= PH_ZERO;
      end else if (sync) begin
         lc_r <= 2'(div_r + PH_STEP);
      end else if (ce1) begin
         lc_r <= lc_r + PH_STEP;
      end
   end
   assign lc_last2 = lc_r[0];
   assign lc_last4 = at_phase(lc_r, PH_LAST4);

   ////////////////////////////////////////////////////////////////////////////
   // source sample, half rate
   logic [DW-1:0] x_r;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         x_r <= WORD_RST;
      end else if (ce2 && out_if.valid) begin
         x_r <= out_if.data;
      end
   end
   assign sample_q = x_r;

   ////////////////////////////////////////////////////////////////////////////
   // down samplers
   logic [1:0] fc_r;
   logic [DW-1:0] first_hold_r;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ds_last_q <= WORD_RST;
      end else if (ce4) begin
         ds_last_q <= x_r;
      end
   end

   // free-running phase, deliberately blind to the clear and to resync
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fc_r <= PH_ZERO;
         first_hold_r <= WORD_RST;
         ds_first_q <= WORD_RST;
      end else if (ce1) begin
         fc_r <= fc_r + PH_STEP;
         if (at_phase(fc_r, PH_ZERO)) begin
            first_hold_r <= x_r;
         end
         if (at_phase(fc_r, PH_LAST4)) begin
            ds_first_q <= first_hold_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // up samplers
   assign us_copy_q = x_r;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         us_zero_q <= WORD_RST;
      end else if (ce1) begin
         us_zero_q <= lc_last2 ? WORD_RST : x_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel interleaver: two byte channels out at full rate
   mrec_phase_type tdm_st_r;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         tdm_st_r <= PH_RUN;
      end else if (sync) begin
         tdm_st_r <= PH_RUN;
      end else if (release_p) begin
         tdm_st_r <= PH_DRAIN;
      end else if (ce1 && lc_last2 && tdm_st_r == PH_DRAIN) begin
         tdm_st_r <= PH_HOLD;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         interleave_q <= CH_ZERO;
      end else if (ce1) begin
         unique case (tdm_st_r)
            PH_HOLD: interleave_q <= CH_ZERO;
            default: interleave_q <= lc_last2 ? x_r[CHW-1:0] : x_r[DW-1:CHW];
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel deinterleaver fed by the interleaver
   logic [CHW-1:0] dch0_r;
   logic deint_hold_r;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         deint_hold_r <= 1'b0;
      end else if (sync) begin
         deint_hold_r <= 1'b0;
      end else if (release_p) begin
         deint_hold_r <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         dch0_r <= CH_ZERO;
         deint_ch0_q <= CH_ZERO;
         deint_ch1_q <= CH_ZERO;
      end else if (ce1 && !deint_hold_r) begin
         // high byte is on the line during odd phases, so it lands in ch0
         if (lc_last2) begin
            dch0_r <= interleave_q;
         end else begin
            deint_ch0_q <= dch0_r;
            deint_ch1_q <= interleave_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // word serializer: one nibble a cycle, most significant first
   mrec_phase_type ser_st_r;
   logic [DW-1:0] ser_buf_r;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ser_st_r <= PH_RUN;
      end else if (sync) begin
         ser_st_r <= PH_RUN;
      end else if (release_p) begin
         ser_st_r <= PH_DRAIN;
      end else if (ce1 && lc_last4 && ser_st_r == PH_DRAIN) begin
         ser_st_r <= PH_HOLD;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ser_buf_r <= WORD_RST;
         ser_q <= NIB_RST;
      end else if (ce1 && ser_st_r != PH_HOLD) begin
         ser_q <= ser_buf_r[(DW-1) - NW*lc_r -: NW];
         if (lc_last4 && ser_st_r == PH_RUN) begin
            ser_buf_r <= x_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // word deserializer fed by the serializer
   logic [DW-NW-1:0] des_sh_r;
   logic [DW-1:0] des_cap_r;

   // full-rate enable is off during clear, so everything here freezes
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         des_sh_r <= '0;
         des_cap_r <= WORD_RST;
      end else if (ce1) begin
         des_sh_r <= {des_sh_r[DW-2*NW-1:0], ser_q};
         // the registered serializer shows a word's last nibble at phase zero
         if (at_phase(lc_r, PH_ZERO) && !arm_r) begin
            des_cap_r <= {des_sh_r, ser_q};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         deser_q <= WORD_RST;
      end else if (ce4) begin
         deser_q <= des_cap_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // tap-select shift register at half rate
   logic [DW-1:0] sr_mem [SR_D];

   // contents survive the clear; shifting resumes with the enables
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sr_mem[0] <= WORD_RST;
      end else if (ce2) begin
         sr_mem[0] <= x_r;
      end
   end

   for (genvar i = 1; i < SR_D; i++) begin : g_sr
      always_ff @(posedge clock) begin
         if (sys_rst) begin
            sr_mem[i] <= WORD_RST;
         end else if (ce2) begin
            sr_mem[i] <= sr_mem[i-1];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sr_q <= WORD_RST;
      end else begin
         sr_q <= sr_mem[sr_addr];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // two-phase decimating filter; its phase only returns to zero on sys_rst or fir_rst,
   // so after a clear the caller must pulse fir_rst to realign it
   logic fph_r;
   logic [DW-1:0] facc_r;

   always_ff @(posedge clock) begin
      if (sys_rst || fir_rst) begin
         fph_r <= 1'b0;
         facc_r <= WORD_RST;
         fir_q <= FIR_RST;
      end else if (ce2) begin
         fph_r <= !fph_r;
         if (!fph_r) begin
            facc_r <= x_r;
         end else begin
            fir_q <= FIR_W'(facc_r) + FIR_W'(x_r);
         end
      end
   end
endmodule : mrec_top
`default_nettype wire

// ==== test/mrec_sys_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module mrec_sys_model (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // request from bench
   input wire logic clr_req,
   // toward the block, and data_ok to the bench
   output logic ce_clear,
   output logic fir_rst,
   output logic data_ok
);
   logic [2:0] settle_r;
   always_ff @(posedge clock) begin
      ce_clear <= !sys_rst && clr_req;
   end
   // filter reset comes from the clear source, once, just after release
   always_ff @(posedge clock) begin
      fir_rst <= !sys_rst && ce_clear && !clr_req;
   end
   // output trusted only once a full quarter-rate period has passed
   always_ff @(posedge clock) begin
      if (sys_rst || ce_clear) begin
         settle_r <= 3'h0;
      end else if (settle_r != 3'h4) begin
         settle_r <= settle_r + 3'h1;
      end
   end
   assign data_ok = settle_r == 3'h4;
endmodule : mrec_sys_model
`default_nettype wire

// ==== test/mrec_top_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module mrec_top_properties (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // enables
   input wire logic ce_clear,
   input wire logic ce1,
   input wire logic ce2,
   input wire logic ce4,
   // rate changer outputs
   input wire logic [mrec_pkg::DW-1:0] sample_q,
   input wire logic [mrec_pkg::DW-1:0] ds_last_q,
   input wire logic [mrec_pkg::DW-1:0] us_copy_q,
   input wire logic [mrec_pkg::DW-1:0] us_zero_q,
   input wire logic [mrec_pkg::CHW-1:0] deint_ch0_q,
   input wire logic [mrec_pkg::CHW-1:0] deint_ch1_q,
   input wire logic [mrec_pkg::NW-1:0] ser_q,
   input wire logic [mrec_pkg::DW-1:0] deser_q
);
   import mrec_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   AST_QUIET_IN_CLEAR: assert property (ce_clear |-> !ce1 && !ce2 && !ce4)
      else $error("enable pulse while clear held");
   AST_PHASE_RESTART: assert property ($fell(ce_clear) |-> ce1 && !ce2
      ##1 ce2 && !ce4 ##1 !ce2 ##1 ce2 && ce4)
      else $error("divider did not restart at phase zero");
   AST_CE4_WITH_CE2: assert property (ce4 |-> ce2 ##1 !ce2)
      else $error("quarter enable off the half-rate grid");
   AST_FULL_RATE: assert property (!ce_clear |-> ce1)
      else $error("full-rate enable missing");
   AST_COPY_IS_WIRE: assert property (us_copy_q == sample_q)
      else $error("copy up sampler differs from sample");
   AST_LAST_FOLLOWS: assert property (ce4 |=> ds_last_q == $past(sample_q))
      else $error("last-value sampler missed its enable");
   AST_LAST_HOLDS: assert property (!ce4 |=> $stable(ds_last_q))
      else $error("last-value sampler moved without enable");
   AST_SAMPLE_ON_CE2: assert property (!ce2 |=> $stable(sample_q))
      else $error("slow sample moved off its enable");
   AST_DESER_ON_CE4: assert property (!ce4 |=> $stable(deser_q))
      else $error("deserializer output moved off its enable");
   AST_FROZEN_IN_CLEAR: assert property (ce_clear |=> $stable(deint_ch0_q)
      && $stable(deint_ch1_q) && $stable(us_zero_q) && $stable(ser_q))
      else $error("local rate changer moved during clear");
   cover property ($fell(ce_clear));
   cover property (ce4 && sample_q != ds_last_q);
   cover property (ce_clear ##1 !ce_clear ##1 ce2);
endmodule : mrec_top_properties
//////////////////////////////
bind mrec_top mrec_top_properties mrec_top_properties_inst (
   .clock(clock), .sys_rst(sys_rst), .ce_clear(ce_clear), .ce1(ce1), .ce2(ce2), .ce4(ce4),
   .sample_q(sample_q), .ds_last_q(ds_last_q), .us_copy_q(us_copy_q), .us_zero_q(us_zero_q),
   .deint_ch0_q(deint_ch0_q), .deint_ch1_q(deint_ch1_q), .ser_q(ser_q), .deser_q(deser_q)
);
`default_nettype wire

// ==== test/test_multirate_enable_clear.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
   $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); end end
module test_multirate_enable_clear;
   import mrec_pkg::*;
   logic clock, sys_rst, clr_req, ce_clear, fir_rst, data_ok, in_valid, in_ready, ce1, ce2, ce4;
   logic [DW-1:0] in_data, sample_q, ds_last_q, ds_first_q, us_copy_q, us_zero_q, deser_q, sr_q;
   logic [CHW-1:0] interleave_q, deint_ch0_q, deint_ch1_q;
   logic [NW-1:0] ser_q;
   logic [SR_AW-1:0] sr_addr;
   logic [FIR_W-1:0] fir_q;
   int err_total = 0;
   int n_tests = 0;
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   mrec_sys_model mrec_sys_model_inst (.clock(clock), .sys_rst(sys_rst), .clr_req(clr_req),
      .ce_clear(ce_clear), .fir_rst(fir_rst), .data_ok(data_ok));
   mrec_top mrec_top_inst (.clock(clock), .sys_rst(sys_rst), .ce_clear(ce_clear),
      .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready), .fir_rst(fir_rst),
      .sr_addr(sr_addr), .ce1(ce1), .ce2(ce2), .ce4(ce4), .sample_q(sample_q),
      .ds_last_q(ds_last_q), .ds_first_q(ds_first_q), .us_copy_q(us_copy_q),
      .us_zero_q(us_zero_q), .interleave_q(interleave_q), .deint_ch0_q(deint_ch0_q),
      .deint_ch1_q(deint_ch1_q), .ser_q(ser_q), .deser_q(deser_q), .sr_q(sr_q), .fir_q(fir_q));
   //////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask : tick
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic timed_out;
      err_total++;
      $display("MISMATCH t=%0t wait bound used up", $time);
      give_verdict();
   endtask : timed_out
   // once the pipeline is full every output settles to the streamed word, or to a byte, a nibble or zero of it, and fir_q to twice it
   task automatic check_word(input logic [DW-1:0] w);
      `CHK(sample_q, w)
      `CHK(ds_last_q, w)
      `CHK(us_copy_q, w)
      `CHK(ds_first_q, w)
      `CHK(deser_q, w)
      `CHK(deint_ch0_q, w[15:8])
      `CHK(deint_ch1_q, w[7:0])
      `CHK(fir_q, {1'b0, w} + {1'b0, w})
      `CHK(interleave_q === w[15:8] || interleave_q === w[7:0], 1'b1)
      `CHK(us_zero_q === w || us_zero_q === 16'h0000, 1'b1)
      `CHK(ser_q === w[15:12] || ser_q === w[11:8] || ser_q === w[7:4] || ser_q === w[3:0], 1'b1)
      for (int a = 0; a < SR_D; a++) begin
         sr_addr = SR_AW'(a);
         tick(1);
         `CHK(sr_q, w)
      end
   endtask : check_word
   task automatic stream(input logic [DW-1:0] w, input int n);
      in_data = w;
      in_valid = 1'b1;
      tick(n);
   endtask : stream
   //////////////////////////////
   // clear stalls the drain, so the buffer fills to its depth plus the head register (FIFO_D + 1 words)
   task automatic t_fill_drain;
      int pushed = 0;
      int seen = 0;
      logic [DW-1:0] last;
      clr_req = 1'b1;
      tick(2);
      in_valid = 1'b1;
      while (in_ready === 1'b1 && pushed < 40) begin
         in_data = 16'h1000 + 16'(pushed);
         tick(1);
         pushed++;
      end
      in_valid = 1'b0;
      `CHK(pushed, FIFO_D + 1)
      last = sample_q;
      clr_req = 1'b0;
      for (int i = 0; i < 100 && seen < pushed; i++) begin
         tick(1);
         if (sample_q !== last) begin
            `CHK(sample_q, 16'h1000 + 16'(seen))
            seen++;
            last = sample_q;
         end
      end
      if (seen < pushed) timed_out();
      `CHK(in_ready, 1'b1)
      $display("done fill_drain");
   endtask : t_fill_drain
   task automatic t_restart;
      logic [2:0] pat [4] = '{3'h4, 3'h6, 3'h4, 3'h7};
      clr_req = 1'b1;
      tick(3);
      `CHK({ce1, ce2, ce4}, 3'h0)
      clr_req = 1'b0;
      for (int i = 0; i < 4; i++) begin
         tick(1);
         `CHK({ce1, ce2, ce4}, pat[i])
      end
      $display("done restart");
   endtask : t_restart
   // new data offered during clear must not reach any stored output
   task automatic t_clear_mid;
      stream(16'hA5C3, 120);
      check_word(16'hA5C3);
      clr_req = 1'b1;
      stream(16'h3C5A, 12);
      check_word(16'hA5C3);
      clr_req = 1'b0;
      for (int i = 0; i < 20 && data_ok !== 1'b1; i++) tick(1);
      if (data_ok !== 1'b1) timed_out();
      stream(16'h3C5A, 120);
      check_word(16'h3C5A);
      $display("done clear_mid");
   endtask : t_clear_mid
   //////////////////////////////
   initial begin
      sys_rst = 1'b1;
      clr_req = 1'b0;
      in_valid = 1'b0;
      in_data = 16'h0000;
      sr_addr = 2'h0;
      repeat (12) @(posedge clock);
      @(negedge clock);
      sys_rst = 1'b0;
      t_fill_drain();
      t_restart();
      t_clear_mid();
      give_verdict();
   end
endmodule : test_multirate_enable_clear
`default_nettype wire
